// ### design/upef_pkg.sv
// package: register map, field positions and timing for the usb power/event block
package upef_pkg;
  // register byte offsets
  localparam logic [7:0] UPEF_OFS_PWR   = 8'h00;
  localparam logic [7:0] UPEF_OFS_FLAGS = 8'h04;
  localparam logic [7:0] UPEF_OFS_ENAB  = 8'h08;
  localparam logic [7:0] UPEF_OFS_ERREN = 8'h0C;
  localparam logic [7:0] UPEF_OFS_MODE  = 8'h10;
  localparam logic [7:0] UPEF_OFS_STAT  = 8'h14;
  // power control fields
  localparam int UPEF_PWR_ON    = 0;
  localparam int UPEF_PWR_SUSP  = 1;
  localparam int UPEF_PWR_BUSY  = 3;
  localparam int UPEF_PWR_GUARD = 4;
  localparam int UPEF_PWR_ACT   = 7;
  // event flag positions
  localparam int UPEF_EV_RST    = 0;
  localparam int UPEF_EV_ERR    = 1;
  localparam int UPEF_EV_SOF    = 2;
  localparam int UPEF_EV_TOK    = 3;
  localparam int UPEF_EV_IDLE   = 4;
  localparam int UPEF_EV_RESUME = 5;
  localparam int UPEF_EV_ATTACH = 6;
  localparam int UPEF_EV_STALL  = 7;
  localparam int UPEF_MODE_HOST = 0;
  localparam logic [7:0]  UPEF_PWR_WMASK = 8'h13;
  localparam logic [7:0]  UPEF_ZERO8     = 8'h00;
  localparam logic [31:0] UPEF_ZERO32    = 32'h0000_0000;
  localparam logic [1:0]  UPEF_HTRANS_NS = 2'h2;
  localparam logic [2:0]  UPEF_HSIZE_W   = 3'h2;
  // timing
  localparam int UPEF_CLK_MHZ    = 50;
  localparam int UPEF_QUIET_NS   = 2500;
  localparam int UPEF_QUIET_CYC  = (UPEF_QUIET_NS * UPEF_CLK_MHZ + 999) / 1000;
  localparam int UPEF_IDLE_MS    = 3;
  localparam int UPEF_IDLE_CYC   = UPEF_IDLE_MS * UPEF_CLK_MHZ * 1000;
  localparam int UPEF_BUSY_CYC   = 4;
  // bus line states seen from the transceiver
  typedef struct packed {
    logic kstate;
    logic se0;
    logic jidle;
    logic active;
  } upef_line_t;
  // engine events, single-cycle pulses
  typedef struct packed {
    logic stall_hs;
    logic sof_tok;
    logic sof_thr;
    logic tok_done;
    logic bus_reset;
    logic detach;
    logic [7:0] err;
  } upef_evt_t;
endpackage

// ### design/upef_top.sv
// usb power control and top-level event flags behind an ahb-lite slave
`timescale 1ns/1ps
module upef_top
  import upef_pkg::*;
#(
  parameter int IDLE_CYCLES = UPEF_IDLE_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [3:0]  line_pins,
  input  wire upef_evt_t   engine_evt,
  input  wire logic [7:0]  tok_status,
  output logic             usb_clk_en,
  output logic             phy_low_power,
  output logic             module_enable,
  output logic             sleep_block,
  output logic             module_interrupt_request,
  output logic             stat_fifo_pop
);
  localparam int QW = 8;
  localparam int IW = 24;
  localparam logic [QW-1:0] QUIET_LAST = QW'(UPEF_QUIET_CYC - 1);
  localparam logic [IW-1:0] IDLE_LAST  = IW'(IDLE_CYCLES - 1);
  localparam logic [QW-1:0] QONE = QW'(1);
  localparam logic [IW-1:0] IONE = IW'(1);
  localparam logic [2:0]    BUSY_LAST = 3'(UPEF_BUSY_CYC - 1);

  typedef enum logic [1:0] {UPEF_OFF, UPEF_WAKE, UPEF_ON, UPEF_DRAIN} upef_pst_t;

  // registers
  logic [7:0]  pwr_ctl_ff, flags_ff, enab_ff, erren_ff, stat_ff;
  logic        host_ff, act_pnd_ff, resp_ff;
  logic [7:0]  nxt_flags;
  upef_pst_t   pst_ff, nxt_pst;
  logic [2:0]  bcnt_ff;
  logic [QW-1:0] quiet_ff, kcnt_ff;
  logic [IW-1:0] icnt_ff;
  logic        ph_wr_ff, ph_rd_ff;
  logic [7:0]  ph_ofs_ff;
  logic [3:0]  s1_ff, s2_ff, s3_ff, line_ff;

  // line synchroniser, a change counts when stages two and three agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff   <= 4'h0;
      s2_ff   <= 4'h0;
      s3_ff   <= 4'h0;
      line_ff <= 4'h0;
    end else begin
      s1_ff <= line_pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      line_ff <= (s2_ff == s3_ff) ? s3_ff : line_ff;
    end
  end
  upef_line_t ln;
  assign ln = upef_line_t'(line_ff);

  // address phase capture and decode
  wire        ap_take = hsel && hready && (htrans == UPEF_HTRANS_NS);
  wire        wr_pwr  = ph_wr_ff && (ph_ofs_ff == UPEF_OFS_PWR);
  wire        wr_flg  = ph_wr_ff && (ph_ofs_ff == UPEF_OFS_FLAGS);
  wire        wr_en   = ph_wr_ff && (ph_ofs_ff == UPEF_OFS_ENAB);
  wire        wr_een  = ph_wr_ff && (ph_ofs_ff == UPEF_OFS_ERREN);
  wire        wr_mode = ph_wr_ff && (ph_ofs_ff == UPEF_OFS_MODE);
  wire [7:0]  wdat    = hwdata[7:0];
  wire        pwr_on  = pwr_ctl_ff[UPEF_PWR_ON];
  wire        susp    = pwr_ctl_ff[UPEF_PWR_SUSP];
  wire        run     = pwr_on && (pst_ff == UPEF_ON);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ph_wr_ff  <= 1'b0;
      ph_rd_ff  <= 1'b0;
      ph_ofs_ff <= UPEF_ZERO8;
    end else begin
      ph_wr_ff  <= ap_take && hwrite && (hsize == UPEF_HSIZE_W);
      ph_rd_ff  <= ap_take && !hwrite;
      ph_ofs_ff <= ap_take ? haddr[7:0] : ph_ofs_ff;
    end
  end

  // power sequencer: busy covers wake-up, on and drain-down
  always_comb begin
    nxt_pst = pst_ff;
    case (pst_ff)
      UPEF_OFF:   if (pwr_on) nxt_pst = UPEF_WAKE;
      UPEF_WAKE:  if (bcnt_ff == BUSY_LAST) nxt_pst = UPEF_ON;
      UPEF_ON:    if (!pwr_on) nxt_pst = UPEF_DRAIN;
      UPEF_DRAIN: if (bcnt_ff == BUSY_LAST) nxt_pst = UPEF_OFF;
      default:    nxt_pst = UPEF_OFF;
    endcase
  end
  wire busy = (pst_ff != UPEF_OFF);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pst_ff  <= UPEF_OFF;
      bcnt_ff <= 3'h0;
    end else begin
      pst_ff  <= nxt_pst;
      bcnt_ff <= (nxt_pst != pst_ff) ? 3'h0 : bcnt_ff + 3'h1;
    end
  end

  // writable control registers; unimplemented bits never stored
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pwr_ctl_ff <= UPEF_ZERO8;
      enab_ff    <= UPEF_ZERO8;
      erren_ff   <= UPEF_ZERO8;
      host_ff    <= 1'b0;
    end else begin
      if (wr_pwr) pwr_ctl_ff <= wdat & UPEF_PWR_WMASK;
      if (wr_en) enab_ff <= wdat;
      if (wr_een) erren_ff <= wdat;
      if (wr_mode) host_ff <= wdat[UPEF_MODE_HOST];
    end
  end

  // bus quiet, k-state and idle timers
  wire quiet_ok = (quiet_ff == QUIET_LAST);
  wire k_hit    = (kcnt_ff == QUIET_LAST - QONE);
  wire idle_hit = (icnt_ff == IDLE_LAST - IONE);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      quiet_ff <= {QW{1'b0}};
      kcnt_ff  <= {QW{1'b0}};
      icnt_ff  <= {IW{1'b0}};
    end else begin
      quiet_ff <= (ln.active || !run) ? {QW{1'b0}} :
                  (quiet_ok ? quiet_ff : quiet_ff + QONE);
      kcnt_ff  <= (!ln.kstate || !pwr_on) ? {QW{1'b0}} :
                  (kcnt_ff == QUIET_LAST ? kcnt_ff : kcnt_ff + QONE);
      icnt_ff  <= (!ln.jidle || !run) ? {IW{1'b0}} :
                  (icnt_ff == IDLE_LAST ? icnt_ff : icnt_ff + IONE);
    end
  end

  // event sources, mode dependent
  logic [7:0] ev_set;
  logic       attach_ff;
  wire attach_now = host_ff && quiet_ok && !ln.se0 && ln.jidle;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) attach_ff <= 1'b0;
    else attach_ff <= attach_now;
  end
  wire [7:0] err_seen = engine_evt.err & erren_ff;
  always_comb begin
    ev_set = UPEF_ZERO8;
    ev_set[UPEF_EV_STALL]  = engine_evt.stall_hs;
    ev_set[UPEF_EV_ATTACH] = attach_now && !attach_ff;
    ev_set[UPEF_EV_RESUME] = k_hit;
    ev_set[UPEF_EV_IDLE]   = idle_hit;
    ev_set[UPEF_EV_TOK]    = engine_evt.tok_done;
    ev_set[UPEF_EV_SOF]    = host_ff ? engine_evt.sof_thr
                                     : engine_evt.sof_tok;
    ev_set[UPEF_EV_ERR]    = |err_seen;
    ev_set[UPEF_EV_RST]    = host_ff ? engine_evt.detach
                                     : engine_evt.bus_reset;
    if (!run) ev_set = UPEF_ZERO8;
  end

  // flags: write one clears, except the error summary; a same-cycle set wins
  wire [7:0] clr_mask = wr_flg ? (wdat & ~(8'h01 << UPEF_EV_ERR)) : UPEF_ZERO8;
  assign nxt_flags = (flags_ff & ~clr_mask) | ev_set;
  wire [7:0] armed = nxt_flags & enab_ff;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flags_ff <= UPEF_ZERO8;
      stat_ff  <= UPEF_ZERO8;
      stat_fifo_pop <= 1'b0;
      module_interrupt_request <= 1'b0;
      act_pnd_ff <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      stat_ff  <= ev_set[UPEF_EV_TOK] ? tok_status : stat_ff;
      stat_fifo_pop <= clr_mask[UPEF_EV_TOK] && flags_ff[UPEF_EV_TOK];
      module_interrupt_request <= |armed;
      act_pnd_ff <= run && ln.active && !(|armed);
    end
  end

  // power pins and sleep guard
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      usb_clk_en    <= 1'b0;
      phy_low_power <= 1'b1;
      module_enable <= 1'b0;
      sleep_block   <= 1'b0;
    end else begin
      usb_clk_en    <= pwr_on && !susp;
      phy_low_power <= !pwr_on || susp;
      module_enable <= run;
      sleep_block   <= pwr_ctl_ff[UPEF_PWR_GUARD] &&
                       (ln.active || act_pnd_ff || (|armed));
    end
  end

  // read mux; unmapped offsets read zero
  logic [7:0] rd_pwr;
  always_comb begin
    rd_pwr = pwr_ctl_ff;
    rd_pwr[UPEF_PWR_BUSY] = busy;
    rd_pwr[UPEF_PWR_ACT]  = act_pnd_ff;
  end
  wire [7:0] rd_sel =
    (ph_ofs_ff == UPEF_OFS_PWR)   ? rd_pwr   :
    (ph_ofs_ff == UPEF_OFS_FLAGS) ? flags_ff :
    (ph_ofs_ff == UPEF_OFS_ENAB)  ? enab_ff  :
    (ph_ofs_ff == UPEF_OFS_ERREN) ? erren_ff :
    (ph_ofs_ff == UPEF_OFS_MODE)  ? {7'h00, host_ff} :
    (ph_ofs_ff == UPEF_OFS_STAT)  ? stat_ff  : UPEF_ZERO8;
  assign hrdata    = ph_rd_ff ? {24'h00_0000, rd_sel} : UPEF_ZERO32;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // checks
  chk_flag_set_wins: assert property (@(posedge ref_clk) disable iff (!nrst)
    ev_set[UPEF_EV_TOK] |=> flags_ff[UPEF_EV_TOK])
    else $error("token flag lost");
  chk_flag_zero_keep: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!wr_flg && flags_ff[UPEF_EV_STALL]) |=> flags_ff[UPEF_EV_STALL])
    else $error("flag cleared without write");
  chk_irq_follows: assert property (@(posedge ref_clk) disable iff (!nrst)
    ##1 module_interrupt_request == |$past(armed))
    else $error("irq mismatch");
  chk_err_masked: assert property (@(posedge ref_clk) disable iff (!nrst)
    (run && |(engine_evt.err & ~erren_ff) && !(|(engine_evt.err & erren_ff))
     && !flags_ff[UPEF_EV_ERR]) |=> !flags_ff[UPEF_EV_ERR])
    else $error("masked error set summary");
  chk_off_no_flags: assert property (@(posedge ref_clk) disable iff (!nrst)
    !run |-> ev_set == UPEF_ZERO8)
    else $error("event while off");
  chk_susp_clk: assert property (@(posedge ref_clk) disable iff (!nrst)
    susp |=> !usb_clk_en && phy_low_power)
    else $error("clock not gated in suspend");
  sequence s_wake;
    pst_ff == UPEF_OFF ##1 pst_ff == UPEF_WAKE;
  endsequence
  chk_busy_wake: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_wake |-> busy [*4])
    else $error("busy dropped during wake");
  chk_guard_off: assert property (@(posedge ref_clk) disable iff (!nrst)
    !pwr_ctl_ff[UPEF_PWR_GUARD] |=> !sleep_block)
    else $error("sleep blocked without guard");
  chk_tok_pop: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wr_flg && wdat[UPEF_EV_TOK] && flags_ff[UPEF_EV_TOK]) |=> stat_fifo_pop)
    else $error("no fifo advance");
  chk_upper_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    hrdata[31:8] == 24'h00_0000)
    else $error("upper bits nonzero");

  // power sequencing and pin relations
  chk_off_disabled: assert property (@(posedge ref_clk) disable iff (!nrst)
    !pwr_on |=> !module_enable && !usb_clk_en && phy_low_power)
    else $error("module active while off");
  chk_run_clk: assert property (@(posedge ref_clk) disable iff (!nrst)
    (pwr_on && !susp) |=> usb_clk_en && !phy_low_power)
    else $error("clock gated while running");
  chk_busy_rise: assert property (@(posedge ref_clk) disable iff (!nrst)
    (pwr_on && !busy) |=> busy)
    else $error("busy missing after power on");
  sequence s_drain;
    pst_ff == UPEF_ON ##1 pst_ff == UPEF_DRAIN;
  endsequence
  chk_busy_drain: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_drain |-> busy [*4])
    else $error("busy dropped during drain");

  // sleep guard and activity pending
  chk_guard_block: assert property (@(posedge ref_clk) disable iff (!nrst)
    (pwr_ctl_ff[UPEF_PWR_GUARD] && ln.active) |=> sleep_block)
    else $error("sleep not blocked on activity");
  chk_act_pend: assert property (@(posedge ref_clk) disable iff (!nrst)
    (run && ln.active && !(|armed)) |=> act_pnd_ff)
    else $error("activity pending missing");
  chk_act_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
    !run |=> !act_pnd_ff)
    else $error("activity pending while off");

  // event sources reach their flags
  chk_stall_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    (run && engine_evt.stall_hs) |=> flags_ff[UPEF_EV_STALL])
    else $error("stall flag not set");
  chk_attach_se0: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ln.se0 || !host_ff) |-> !ev_set[UPEF_EV_ATTACH])
    else $error("attach outside host idle bus");
  chk_resume_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    (run && k_hit) |=> flags_ff[UPEF_EV_RESUME])
    else $error("resume flag not set");
  chk_idle_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    (run && idle_hit) |=> flags_ff[UPEF_EV_IDLE])
    else $error("idle flag not set");
  chk_tok_stat: assert property (@(posedge ref_clk) disable iff (!nrst)
    (run && engine_evt.tok_done) |=> stat_ff == $past(tok_status))
    else $error("token status not captured");
  chk_sof_host: assert property (@(posedge ref_clk) disable iff (!nrst)
    (run && host_ff && engine_evt.sof_thr) |=> flags_ff[UPEF_EV_SOF])
    else $error("frame flag missed in host");
  chk_err_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wr_flg && flags_ff[UPEF_EV_ERR]) |=> flags_ff[UPEF_EV_ERR])
    else $error("error summary cleared by write");
  chk_rst_dev: assert property (@(posedge ref_clk) disable iff (!nrst)
    (run && !host_ff && engine_evt.bus_reset) |=> flags_ff[UPEF_EV_RST])
    else $error("bus reset flag missed");
  chk_detach_host: assert property (@(posedge ref_clk) disable iff (!nrst)
    (run && host_ff && engine_evt.detach) |=> flags_ff[UPEF_EV_RST])
    else $error("detach flag missed");
  chk_enab_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    (enab_ff == UPEF_ZERO8) |=> !module_interrupt_request)
    else $error("request with all enables off");
endmodule

// ### dv/upef_partner.sv
// far-side model: usb line states and engine event pulses
`timescale 1ns/1ps
module upef_partner (
  input  wire logic        ref_clk,
  output logic      [3:0]  line_pins,
  output logic      [13:0] engine_evt
);
  // quiet bus with no engine events from time zero
  initial begin
    line_pins  = 4'h0;
    engine_evt = 14'h0000;
  end
  // line state holds until the next call
  task automatic set_line(input logic [3:0] v);
    line_pins <= v;
  endtask
  // one-cycle event pulse, launched just after an edge
  task automatic fire(input logic [13:0] e);
    engine_evt <= e;
    @(posedge ref_clk);
    engine_evt <= 14'h0000;
  endtask
endmodule

// ### dv/upef_top_tb.sv
// self-checking bench for the usb power and event flag block
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  n_mismatch++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module upef_top_tb
  import upef_pkg::*;
;
  localparam int IDLE_N = 200;
  logic        ref_clk, nrst, hsel, hwrite, hreadyout, hresp;
  logic        usb_clk_en, phy_low_power, module_enable, sleep_block;
  logic        irq, stat_fifo_pop;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  line_pins;
  logic [7:0]  tok_status;
  logic [13:0] engine_evt;
  logic [31:0] haddr, hwdata, hrdata, q, rng;
  int          n_mismatch, checks_done, n_pop;
  // free-running 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // count queue-advance pulses
  always @(posedge ref_clk) if (stat_fifo_pop === 1'b1) n_pop++;
  upef_top #(.IDLE_CYCLES(IDLE_N)) i_upef_top (
    .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .line_pins(line_pins), .engine_evt(engine_evt),
    .tok_status(tok_status), .usb_clk_en(usb_clk_en),
    .phy_low_power(phy_low_power), .module_enable(module_enable),
    .sleep_block(sleep_block), .module_interrupt_request(irq),
    .stat_fifo_pop(stat_fifo_pop));
  upef_partner i_partner (
    .ref_clk(ref_clk), .line_pins(line_pins), .engine_evt(engine_evt));
  // xorshift source for enables and token status
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one ahb-lite single word transfer, read data lands in q
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= UPEF_HTRANS_NS;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 64);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 64);
    q = hrdata;
    if (n >= 64) n_mismatch++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, UPEF_ZERO32);
    `CHK(q, e)
    `CHK(hresp, 1'b0)
  endtask
  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  initial begin
    tick(20000);
    n_mismatch++;
    end_sim();
  end
  // main sequence
  initial begin
    int         hk[7] = '{0, 0, 0, 0, 1, 1, 1};
    int         ek[7] = '{5, 4, 2, 1, 5, 3, 0};
    int         fb[7] = '{7, 2, 3, 0, 7, 2, 0};
    logic [7:0] en, ts, ex;
    int         pc;
    rng = 32'h0000_e2a8;
    {nrst, hsel, hwrite, htrans, haddr, hwdata, tok_status} = '0;
    hsize = UPEF_HSIZE_W;
    tick(10);
    nrst <= 1'b1;
    rchk(UPEF_OFS_PWR, UPEF_ZERO32);
    rchk(UPEF_OFS_FLAGS, UPEF_ZERO32);
    rchk(UPEF_OFS_ENAB, UPEF_ZERO32);
    rchk(8'h18, UPEF_ZERO32);
    i_partner.fire(14'h2000);
    tick(2);
    rchk(UPEF_OFS_FLAGS, UPEF_ZERO32);
    `CHK({module_enable, usb_clk_en, phy_low_power}, 3'b001)
    wr(UPEF_OFS_PWR, 32'h0000_0001);
    rchk(UPEF_OFS_PWR, 32'h0000_0009);
    tick(6);
    `CHK({module_enable, usb_clk_en, phy_low_power}, 3'b110)
    wr(UPEF_OFS_PWR, 32'h0000_0003);
    tick(2);
    `CHK({usb_clk_en, phy_low_power}, 2'b01)
    wr(UPEF_OFS_PWR, 32'h0000_0001);
    tick(2);
    `CHK({usb_clk_en, phy_low_power}, 2'b10)
    wr(UPEF_OFS_PWR, UPEF_ZERO32);
    rchk(UPEF_OFS_PWR, 32'h0000_0008);
    tick(8); // no register access until drained
    rchk(UPEF_OFS_PWR, UPEF_ZERO32);
    wr(UPEF_OFS_PWR, 32'h0000_0001);
    tick(8);
    wr(UPEF_OFS_ENAB, 32'hffff_ffff);
    rchk(UPEF_OFS_ENAB, 32'h0000_00ff);
    hsize <= 3'h0;
    wr(UPEF_OFS_ENAB, 32'h0000_0055);
    hsize <= UPEF_HSIZE_W;
    rchk(UPEF_OFS_ENAB, 32'h0000_00ff);
    $display("power and map test done");
    for (int i = 0; i < 7; i++) begin
      en = 8'(rnd()) & 8'hdf; // resume enable kept off
      ts = 8'(rnd());
      wr(UPEF_OFS_ENAB, {24'h00_0000, en});
      wr(UPEF_OFS_MODE, 32'(hk[i]));
      tok_status <= ts;
      i_partner.fire(14'h0001 << (8 + ek[i]));
      tick(2);
      ex = 8'h01 << fb[i];
      rchk(UPEF_OFS_FLAGS, {24'h00_0000, ex});
      `CHK(irq, |(ex & en))
      wr(UPEF_OFS_FLAGS, ~{24'h00_0000, ex});
      rchk(UPEF_OFS_FLAGS, {24'h00_0000, ex});
      if (fb[i] == 3) rchk(UPEF_OFS_STAT, {24'h00_0000, ts});
      pc = n_pop;
      wr(UPEF_OFS_FLAGS, {24'h00_0000, ex});
      tick(2);
      rchk(UPEF_OFS_FLAGS, UPEF_ZERO32);
      `CHK(irq, 1'b0)
      if (fb[i] == 3) `CHK(n_pop, pc + 1)
    end
    $display("event flag test done");
    wr(UPEF_OFS_ENAB, UPEF_ZERO32);
    rchk(UPEF_OFS_MODE, 32'h0000_0001);
    i_partner.set_line(4'h2);
    tick(150);
    rchk(UPEF_OFS_FLAGS, 32'h0000_0040);
    tick(IDLE_N - 130);
    rchk(UPEF_OFS_FLAGS, 32'h0000_0050);
    i_partner.set_line(4'h8);
    tick(140);
    rchk(UPEF_OFS_FLAGS, 32'h0000_0070);
    i_partner.set_line(4'h0);
    tick(6);
    wr(UPEF_OFS_FLAGS, 32'h0000_0070);
    rchk(UPEF_OFS_FLAGS, UPEF_ZERO32);
    wr(UPEF_OFS_MODE, UPEF_ZERO32);
    i_partner.set_line(4'h1);
    tick(8);
    `CHK(sleep_block, 1'b0)
    rchk(UPEF_OFS_PWR, 32'h0000_0089);
    wr(UPEF_OFS_PWR, 32'h0000_0011);
    tick(4);
    `CHK(sleep_block, 1'b1)
    wr(UPEF_OFS_ENAB, 32'h0000_0080);
    i_partner.fire(14'h2000);
    tick(2);
    rchk(UPEF_OFS_PWR, 32'h0000_0019);
    i_partner.set_line(4'h0);
    wr(UPEF_OFS_FLAGS, 32'h0000_0080);
    $display("line and guard test done");
    wr(UPEF_OFS_ERREN, 32'h0000_0001);
    wr(UPEF_OFS_ENAB, UPEF_ZERO32);
    i_partner.fire(14'h0002);
    tick(2);
    rchk(UPEF_OFS_FLAGS, UPEF_ZERO32);
    i_partner.fire(14'h0001);
    tick(2);
    rchk(UPEF_OFS_FLAGS, 32'h0000_0002);
    `CHK(irq, 1'b0)
    wr(UPEF_OFS_ENAB, 32'h0000_0002);
    tick(2);
    `CHK(irq, 1'b1)
    $display("error summary test done");
    end_sim();
  end
endmodule
